// [hw/ppol_cfg.svh]
`ifndef PPOL_CFG_SVH
`define PPOL_CFG_SVH
// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define PPOL_IDX_A_PIN   6'h00
`define PPOL_IDX_A_DIR   6'h01
`define PPOL_IDX_A_OUT   6'h02
`define PPOL_IDX_B_PIN   6'h03
`define PPOL_IDX_B_DIR   6'h04
`define PPOL_IDX_B_OUT   6'h05
`define PPOL_IDX_C_OUT   6'h08
`define PPOL_IDX_D_PIN   6'h09
`define PPOL_IDX_D_DIR   6'h0A
`define PPOL_IDX_D_OUT   6'h0B
`define PPOL_IDX_CORE    6'h35
`define PPOL_IDX_ALT     6'h3E
`define PPOL_IDX_PCMASK  6'h3F
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define PPOL_CORE_PUOFF_BIT 4
`define PPOL_CORE_WMASK     8'hF3
`define PPOL_ALT_RX0_BIT    0
`define PPOL_ALT_TX0_BIT    1
`define PPOL_ALT_RX1_BIT    2
`define PPOL_ALT_TX1_BIT    3
`define PPOL_ALT_GROUP3_CHANGE_IRQ_ON_BIT  4
`define PPOL_ALT_EXTERNAL_IRQ_LINE_0_BIT   5
`define PPOL_ALT_EXTERNAL_IRQ_LINE_1_BIT   6
`define PPOL_RST_BYTE       8'h00
`endif

// [hw/ppol_pkg.sv]
package ppol_pkg;
   typedef logic [7:0] ppol_byte_t;    // One port byte
   typedef enum logic [1:0] {
      PPOL_IDLE,
      PPOL_ACK
   } ppol_bus_e;                         // Bus slave phase
endpackage : ppol_pkg

// [hw/ppol_pin_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Per-port pin control bundle between top and port slices
interface ppol_pin_if;
   logic [7:0] dir;      // Register direction bits
   logic [7:0] outv;     // Output-value bits
   logic       pu_off;   // Global pull-up disable
   logic [7:0] direction_override_enable;     // Direction override enable
   logic [7:0] direction_override_value;     // Direction override value
   logic [7:0] drive_value_override_enable;     // Drive value override enable
   logic [7:0] drive_value_override_value;     // Drive value override value
   logic [7:0] pullup_override_enable;     // Pull-up override enable
   logic [7:0] pullup_override_value;     // Pull-up override value
   logic [7:0] pin_oe;   // Resolved output enable
   logic [7:0] pin_o;    // Resolved driven value
   logic [7:0] pin_pu;   // Resolved pull-up
   modport ctl (output dir, outv, pu_off, direction_override_enable, direction_override_value, drive_value_override_enable, drive_value_override_value, pullup_override_enable, pullup_override_value,
                input pin_oe, pin_o, pin_pu);
   modport slice (input dir, outv, pu_off, direction_override_enable, direction_override_value, drive_value_override_enable, drive_value_override_value, pullup_override_enable, pullup_override_value,
                  output pin_oe, pin_o, pin_pu);
endinterface : ppol_pin_if
`default_nettype wire

// [hw/ppol_pin_slice.sv]
`timescale 1ns/1ps
`default_nettype none
// Resolves direction, value and pull-up for one 8-bit port
module ppol_pin_slice
   import ppol_pkg::*;
(
   ppol_pin_if.slice p
);
   // ----------------------------------------
   // Override resolution per pin
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_pin
         wire eff_dir;   // Direction after override
         assign eff_dir = p.direction_override_enable[i] ? p.direction_override_value[i] : p.dir[i];
         assign p.pin_oe[i] = eff_dir;
         assign p.pin_o[i]  = p.drive_value_override_enable[i] ? p.drive_value_override_value[i] : p.outv[i];
         // Pull-up only on an input with the value bit set, never under disable
         assign p.pin_pu[i] = p.pullup_override_enable[i] ? p.pullup_override_value[i]
                            : (~eff_dir & p.outv[i] & ~p.pu_off);
      end
   endgenerate
endmodule : ppol_pin_slice
`default_nettype wire

// [hw/ppol_gpio.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ppol_cfg.svh"
module ppol_gpio
   import ppol_pkg::*;
#(
   parameter int NPORT = 4    // Ports A..D, D carries overrides
)(
   input  wire  logic        clk,
   input  wire  logic        nrst,
   input  wire  logic [7:0]  avs_address,
   input  wire  logic        avs_read,
   input  wire  logic        avs_write,
   input  wire  logic [31:0] avs_writedata,
   input  wire  logic [3:0]  avs_byteenable,
   output var   logic [31:0] avs_readdata,
   output var   logic        avs_waitrequest,
   input  wire  logic [31:0] pin_in,
   output var   logic [31:0] pin_out,
   output var   logic [31:0] pin_oe,
   output var   logic [31:0] pin_pullup,
   output var   logic [7:0]  portd_digital_in,
   output var   logic [7:0]  portd_input_enable,
   input  wire  logic        serial0_transmit_line,
   input  wire  logic        serial1_transmit_line,
   input  wire  logic [3:0]  compare_out,
   input  wire  logic [3:0]  compare_out_on
);
   // ----------------------------------------
   // Elaboration check
   // ----------------------------------------
   // Port D override wiring and the index map are built for four ports;
   // any other count is refused at elaboration, not left to misbehave
   // quietly in silicon
   if (NPORT != 4) begin : g_bad_nport
      $error("ppol_gpio supports exactly four ports");
   end

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic [7:0]  dir_ff [4];     // Direction per port, C unused
   logic [7:0]  outv_ff [4];    // Output value per port
   logic [7:0]  core_ff;        // Core control byte
   logic [7:0]  alt_ff;         // Serial enables and irq enables
   logic [7:0]  pcmask_ff;      // Port D pin-change mask
   logic [31:0] sync1_ff;       // Pin synchroniser stage 1
   logic [31:0] sync2_ff;       // Stage 2
   logic [31:0] sync3_ff;       // Stage 3
   logic [31:0] level_ff;       // Debounced pin levels
   ppol_bus_e   phase_ff;       // Bus answer phase
   // Register bytes take reset values from the config header; pin stages and levels reset to zero.
   // Limitations worth knowing:
   //   only byte lane 0 carries data, upper read lanes are zero
   //   pin level registers ignore writes, they follow the pins
   //   port C has no direction register, its pins are inputs
   //   unmapped writes are dropped, unmapped reads return zero

   // ----------------------------------------
   // Avalon decode
   // ----------------------------------------
   // One register per 32-bit word, so the byte address drops two bits
   wire [5:0] idx;              // Word index
   wire       wr_lane0;         // Write reaching the byte lane, at the ack edge
   wire       acc;              // Request first seen in the idle phase
   wire       wr_core;          // Write to core control
   wire       wr_alt;           // Write to serial and irq enables
   wire       wr_pcmask;        // Write to pin-change mask
   // Reads are looked up on the first edge so the data stands in the ack
   // cycle; writes wait for the ack edge, the one edge the master commits at
   assign idx       = avs_address[7:2];
   assign acc       = (phase_ff == PPOL_IDLE) && (avs_read || avs_write);
   assign wr_lane0  = (phase_ff == PPOL_ACK) && avs_write && avs_byteenable[0];
   assign wr_core   = wr_lane0 && (idx == `PPOL_IDX_CORE);
   assign wr_alt    = wr_lane0 && (idx == `PPOL_IDX_ALT);
   assign wr_pcmask = wr_lane0 && (idx == `PPOL_IDX_PCMASK);

   // Lookup of an index to a port number for direction/output registers;
   // a function because both write targets decode the same map.
   // The value 7 marks an index that belongs to neither map, so no
   // port slot ever matches it.
   function automatic logic [2:0] port_of(input logic [5:0] a, input logic is_out);
      logic [2:0] r;
      r = 3'h7;
      if (!is_out && a == `PPOL_IDX_A_DIR) r = 3'h0;
      if (!is_out && a == `PPOL_IDX_B_DIR) r = 3'h1;
      if (!is_out && a == `PPOL_IDX_D_DIR) r = 3'h3;
      if (is_out && a == `PPOL_IDX_A_OUT) r = 3'h0;
      if (is_out && a == `PPOL_IDX_B_OUT) r = 3'h1;
      if (is_out && a == `PPOL_IDX_C_OUT) r = 3'h2;
      if (is_out && a == `PPOL_IDX_D_OUT) r = 3'h3;
      return r;
   endfunction : port_of

   wire [2:0] wdir_port;        // Direction target
   wire [2:0] wout_port;        // Output-value target
   assign wdir_port = port_of(idx, 1'b0);
   assign wout_port = port_of(idx, 1'b1);

   // ----------------------------------------
   // Bus phase: one wait state then ack
   // ----------------------------------------
   // A request seen in idle moves to ack; the master still holds it there
   // and samples waitrequest low at the next edge, the commit edge.
   // A fixed single wait state keeps the read mux off the critical path.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         phase_ff <= PPOL_IDLE;
      end else begin
         case (phase_ff)
            PPOL_IDLE: phase_ff <= (avs_read || avs_write) ? PPOL_ACK : PPOL_IDLE;
            // Ack lasts one cycle; the next request starts from idle
            PPOL_ACK:  phase_ff <= PPOL_IDLE;
            default:   phase_ff <= PPOL_IDLE;
         endcase
      end
   end

   // Waitrequest low only in the ack phase
   // Registered so the port comes from a flip-flop; reset and idle hold
   // it high, so a master never sees a stale acknowledge
   // between two requests
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((phase_ff == PPOL_IDLE) && (avs_read || avs_write));
      end
   end

   // ----------------------------------------
   // Register writes, taken at the ack edge
   // ----------------------------------------
   // Port C has no direction register: its slot keeps the reset value and
   // is never written, so the slice sees zeros and its pins stay inputs
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_port
         // One port per access; the decode picks at most one target
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               dir_ff[g]  <= `PPOL_RST_BYTE;
               outv_ff[g] <= `PPOL_RST_BYTE;
            end else begin
               if (wr_lane0 && wdir_port == 3'(g) && g != 2) begin
                  dir_ff[g] <= avs_writedata[7:0];
               end
               if (wr_lane0 && wout_port == 3'(g)) begin
                  outv_ff[g] <= avs_writedata[7:0];
               end
            end
         end
      end
   endgenerate

   // Control bytes
   // Core control drops writes to bits 3:2 so they always read zero;
   // the enable byte has nothing behind bit 7, so it reads zero too
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         // Pull-ups allowed, serial and irq enables off
         core_ff   <= `PPOL_RST_BYTE;
         alt_ff    <= `PPOL_RST_BYTE;
         pcmask_ff <= `PPOL_RST_BYTE;
      end else begin
         if (wr_core) begin
            core_ff <= avs_writedata[7:0] & `PPOL_CORE_WMASK;
         end
         if (wr_alt) begin
            alt_ff <= {1'b0, avs_writedata[6:0]};
         end
         if (wr_pcmask) begin
            pcmask_ff <= avs_writedata[7:0];
         end
      end
   end

   // ----------------------------------------
   // Pin synchroniser: change counts once stages 2 and 3 agree
   // ----------------------------------------
   // Pins are asynchronous: stage 1 may go metastable and only stage 2
   // reads it. A level moves only once stages 2 and 3 agree, which costs
   // a cycle of latency but keeps a one-cycle glitch out of the input
   // registers and the irq path.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         // All stages clear so the first level comes from real samples
         sync1_ff <= 32'h00000000;
         sync2_ff <= 32'h00000000;
         sync3_ff <= 32'h00000000;
         level_ff <= 32'h00000000;
      end else begin
         sync1_ff <= pin_in;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         level_ff <= (sync2_ff & sync3_ff) | (level_ff & (sync2_ff | sync3_ff));
      end
   end

   // ----------------------------------------
   // Port D override terms
   // ----------------------------------------
   // Only port D has overrides. Bits 3:0 follow the serial enables, bits
   // 7:4 take compare values and nothing else. Enable byte layout, low
   // bit first: rx0, tx0, rx1, tx1, group 3 pin change, irq 0, irq 1.
   // Serial enable bits get names once so every override term below reads alike.
   wire pu_off;                  // Global pull-up disable
   wire rx0, tx0, rx1, tx1;      // Serial enables
   assign pu_off = core_ff[`PPOL_CORE_PUOFF_BIT];
   assign rx0    = alt_ff[`PPOL_ALT_RX0_BIT];
   assign tx0    = alt_ff[`PPOL_ALT_TX0_BIT];
   assign rx1    = alt_ff[`PPOL_ALT_RX1_BIT];
   assign tx1    = alt_ff[`PPOL_ALT_TX1_BIT];

   // Transmit pins are forced out, receive pins are forced in;
   // a transmit pin never pulls up since it is always driven
   wire [7:0] d_direction_override_enable, d_direction_override_value, d_drive_value_override_enable, d_drive_value_override_value, d_pullup_override_enable, d_pullup_override_value;
   assign d_direction_override_enable = {4'h0, tx1, rx1, tx0, rx0};
   assign d_direction_override_value = {4'h0, 1'b1, 1'b0, 1'b1, 1'b0};
   assign d_drive_value_override_enable = {compare_out_on, tx1, 1'b0, tx0, 1'b0};
   assign d_drive_value_override_value = {compare_out, serial1_transmit_line, 1'b0,
                    serial0_transmit_line, 1'b0};
   assign d_pullup_override_enable = {4'h0, tx1, rx1, tx0, rx0};
   // Receive pins keep the value bit as pull-up, gated by the disable
   assign d_pullup_override_value = {4'h0, 1'b0, outv_ff[3][2] & ~pu_off, 1'b0,
                    outv_ff[3][0] & ~pu_off};

   // Digital input kept alive by pin-change or external irq enables
   // External irq 0 sits on bit 2 and irq 1 on bit 3
   wire [7:0] d_die;
   assign d_die = (pcmask_ff & {8{alt_ff[`PPOL_ALT_GROUP3_CHANGE_IRQ_ON_BIT]}})
                | {4'h0, alt_ff[`PPOL_ALT_EXTERNAL_IRQ_LINE_1_BIT], alt_ff[`PPOL_ALT_EXTERNAL_IRQ_LINE_0_BIT], 2'b00};

   // ----------------------------------------
   // Port slices
   // ----------------------------------------
   // One interface per port carries register bits and override terms
   // into a slice. Ports A to C get all-zero overrides, port C also a
   // zero direction byte since it has no direction register.
   logic [31:0] res_oe, res_o, res_pu;   // Resolved pin controls
   generate
      for (g = 0; g < 4; g++) begin : g_slice
         ppol_pin_if pif ();
         // Direction bits, zero for port C
         assign pif.dir    = (g == 2) ? 8'h00 : dir_ff[g];
         assign pif.outv   = outv_ff[g];
         assign pif.pu_off = pu_off;
         assign pif.direction_override_enable   = (g == 3) ? d_direction_override_enable : 8'h00;
         assign pif.direction_override_value   = (g == 3) ? d_direction_override_value : 8'h00;
         assign pif.drive_value_override_enable   = (g == 3) ? d_drive_value_override_enable : 8'h00;
         assign pif.drive_value_override_value   = (g == 3) ? d_drive_value_override_value : 8'h00;
         assign pif.pullup_override_enable   = (g == 3) ? d_pullup_override_enable : 8'h00;
         assign pif.pullup_override_value   = (g == 3) ? d_pullup_override_value : 8'h00;
         ppol_pin_slice u_slice (
            .p (pif.slice)
         );
         assign res_oe[g*8 +: 8] = pif.pin_oe;
         assign res_o[g*8 +: 8]  = pif.pin_o;
         assign res_pu[g*8 +: 8] = pif.pin_pu;
      end
   endgenerate

   // Registered pin outputs
   // Costs one cycle after each write, but the pads see clean edges and
   // no decode glitch ever reaches a pin
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_oe     <= 32'h00000000;
         pin_out    <= 32'h00000000;
         pin_pullup <= 32'h00000000;
      end else begin
         pin_oe     <= res_oe;
         pin_out    <= res_o;
         pin_pullup <= res_pu;
      end
   end

   // Port D digital inputs toward the irq logic
   // A pin with no enable reads low, so a floating pad cannot raise an
   // irq; the enable itself is exported for the irq logic
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         portd_digital_in   <= 8'h00;
         portd_input_enable <= 8'h00;
      end else begin
         portd_digital_in   <= level_ff[31:24] & d_die;
         portd_input_enable <= d_die;
      end
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   // Decoded from the word index alone; the phase gate sits at capture.
   // Port C pin levels are not readable in this block.
   logic [7:0] rd_byte;          // Selected register byte
   always_comb begin
      case (idx)
         `PPOL_IDX_A_PIN:  rd_byte = level_ff[7:0];
         `PPOL_IDX_B_PIN:  rd_byte = level_ff[15:8];
         `PPOL_IDX_D_PIN:  rd_byte = level_ff[31:24];
         `PPOL_IDX_A_DIR:  rd_byte = dir_ff[0];
         `PPOL_IDX_B_DIR:  rd_byte = dir_ff[1];
         `PPOL_IDX_D_DIR:  rd_byte = dir_ff[3];
         `PPOL_IDX_A_OUT:  rd_byte = outv_ff[0];
         `PPOL_IDX_B_OUT:  rd_byte = outv_ff[1];
         `PPOL_IDX_C_OUT:  rd_byte = outv_ff[2];
         `PPOL_IDX_D_OUT:  rd_byte = outv_ff[3];
         `PPOL_IDX_CORE:   rd_byte = core_ff;
         `PPOL_IDX_ALT:    rd_byte = alt_ff;
         `PPOL_IDX_PCMASK: rd_byte = pcmask_ff;
         default:          rd_byte = 8'h00;                   // Unmapped reads zero
      endcase
   end

   // Read data registered with the ack
   // Captured on the first edge and held until the next read, so the
   // data stands at the edge where the master takes it; other lanes
   // stay zero
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         avs_readdata <= 32'h00000000;
      end else if (acc && avs_read) begin
         avs_readdata <= {24'h000000, rd_byte};
      end
   end
endmodule : ppol_gpio
`default_nettype wire

// [verif/ppol_pins_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Board and peripherals behind port pins
// ----------------------------------------
module ppol_pins_model (
   input  wire logic        clk,
   input  wire logic [31:0] pin_out,
   input  wire logic [31:0] pin_oe,
   input  wire logic [31:0] pin_pullup,
   input  wire logic [31:0] ext_drv,
   input  wire logic [31:0] ext_en,
   output var  logic [31:0] pin_in
);
   logic [31:0] float_ff; // Undriven pins wander, never hold a level
   // Toggle pattern so a floating pin is never read as stable
   always @(posedge clk) begin
      float_ff <= ~float_ff;
   end
   initial float_ff = 32'h55555555;
   // Device drive wins, then board drive, then pull-up or float
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_drv)
                 | (~pin_oe & ~ext_en & (pin_pullup | float_ff));
endmodule : ppol_pins_model
`default_nettype wire

// [verif/ppol_gpio_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ppol_cfg.svh"
module ppol_gpio_monitor
   import ppol_pkg::*;
(
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic        avs_waitrequest,
   input wire logic [7:0]  avs_address,
   input wire logic [7:0]  portd_digital_in,
   input wire logic [7:0]  portd_input_enable,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic [31:0] pin_in,
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe,
   input wire logic [31:0] pin_pullup,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [3:0]  compare_out,
   input wire logic [3:0]  compare_out_on,
   input wire logic        serial0_transmit_line,
   input wire logic        serial1_transmit_line
);
   // ----------------------------------------
   // Shadow of control registers
   // ----------------------------------------
   logic [7:0] alt_ff, core_ff, pcm_ff;                  // Shadow copies
   wire wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0]; // Accepted write
   wire [5:0] idx = avs_address[7:2];                   // Word index
   // Track writes at the ack edge, as the slave does
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         alt_ff <= 8'h00; core_ff <= 8'h00; pcm_ff <= 8'h00;
      end else if (wr_ok) begin
         if (idx == `PPOL_IDX_ALT) alt_ff <= avs_writedata[7:0];
         if (idx == `PPOL_IDX_CORE) core_ff <= avs_writedata[7:0];
         if (idx == `PPOL_IDX_PCMASK) pcm_ff <= avs_writedata[7:0];
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   AST_ONE_WAIT: assert property (@(posedge clk) disable iff (!nrst)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("ack late");
   AST_ACK_PULSE: assert property (@(posedge clk) disable iff (!nrst)
      !avs_waitrequest |=> avs_waitrequest) else $error("ack too long");
   AST_PU_OE: assert property (@(posedge clk) disable iff (!nrst)
      (pin_pullup & pin_oe) == 32'h0) else $error("pull-up on driven pin");
   AST_PUD: assert property (@(posedge clk) disable iff (!nrst)
      core_ff[4] |=> pin_pullup == 32'h0) else $error("pull-up despite disable");
   AST_RX0: assert property (@(posedge clk) disable iff (!nrst)
      alt_ff[0] |=> !pin_oe[24]) else $error("rx0 pin driven");
   AST_RX1: assert property (@(posedge clk) disable iff (!nrst)
      alt_ff[2] |=> !pin_oe[26]) else $error("rx1 pin driven");
   AST_TX0: assert property (@(posedge clk) disable iff (!nrst)
      alt_ff[1] |=> pin_oe[25] && pin_out[25] == $past(serial0_transmit_line)) else $error("tx0 wrong");
   AST_TX1: assert property (@(posedge clk) disable iff (!nrst)
      alt_ff[3] |=> pin_oe[27] && !pin_pullup[27] && pin_out[27] == $past(serial1_transmit_line))
      else $error("tx1 wrong");
   AST_CMP: assert property (@(posedge clk) disable iff (!nrst)
      compare_out_on[1] |=> pin_out[29] == $past(compare_out[1])) else $error("compare value wrong");
   AST_DIE: assert property (@(posedge clk) disable iff (!nrst)
      (pcm_ff[2] && alt_ff[4]) || alt_ff[5] |=> portd_input_enable[2]) else $error("input off");
endmodule : ppol_gpio_monitor
bind ppol_gpio ppol_gpio_monitor i_ppol_gpio_monitor (.clk(clk), .nrst(nrst), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
   .portd_digital_in(portd_digital_in), .portd_input_enable(portd_input_enable),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .pin_in(pin_in), .pin_out(pin_out),
   .pin_oe(pin_oe), .pin_pullup(pin_pullup), .avs_byteenable(avs_byteenable),
   .compare_out(compare_out), .compare_out_on(compare_out_on),
   .serial0_transmit_line(serial0_transmit_line), .serial1_transmit_line(serial1_transmit_line));
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top
   import ppol_pkg::*;
;
   logic clk, nrst, rd, wr, tx0, tx1, wq;         // Bench-side signals
   logic [7:0]  addr, die, dien;                   // Bus address, port D inputs
   logic [31:0] wdat, rdat, pin_in, pout, poe, ppu, ext_drv, ext_en; // Data and pins
   logic [3:0]  cmp, cmp_on;                       // Compare outputs
   int error_cnt, comparisons;                     // Verdict counters
   ppol_gpio i_ppol_gpio (.clk(clk), .nrst(nrst), .avs_address(addr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wdat), .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wq),
      .pin_in(pin_in), .pin_out(pout), .pin_oe(poe), .pin_pullup(ppu), .portd_digital_in(die),
      .portd_input_enable(dien), .serial0_transmit_line(tx0), .serial1_transmit_line(tx1),
      .compare_out(cmp), .compare_out_on(cmp_on));
   ppol_pins_model i_ppol_pins_model (.clk(clk), .pin_out(pout), .pin_oe(poe), .pin_pullup(ppu),
      .ext_drv(ext_drv), .ext_en(ext_en), .pin_in(pin_in));
   // ----------------------------------------
   // Bus cycles: hold until waitrequest seen low
   // ----------------------------------------
   task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      addr <= {idx, 2'b00}; wdat <= {24'h000000, d}; wr <= w; rd <= ~w;
      do begin @(posedge clk); n++; end while (wq !== 1'b0 && n < 50);
      q = rdat[7:0];
      if (n >= 50) begin
         error_cnt++;
         $display("[ERR] waitrequest exp 0 got %b", wq);
         wrap_up();
      end
      wr <= 1'b0; rd <= 1'b0;
      @(posedge clk);                               // Gap keeps strobes single-assigned
   endtask : bus
   task automatic wreg(input logic [5:0] idx, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, idx, d, q);
   endtask : wreg
   task automatic rchk(input logic [5:0] idx, input logic [7:0] e);
      logic [7:0] q;
      bus(1'b0, idx, 8'h00, q);
      `CHK("reg", e, q)
   endtask : rchk
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs;
      logic [5:0] ix[7] = '{6'h01, 6'h02, 6'h04, 6'h05, 6'h08, 6'h0A, 6'h0B};
      foreach (ix[i]) rchk(ix[i], 8'h00);
      rchk(6'h35, 8'h00);
      `CHK("oe_rst", 32'h0, poe)
      foreach (ix[i]) wreg(ix[i], 8'h3C ^ {2'h0, ix[i]});
      foreach (ix[i]) rchk(ix[i], 8'h3C ^ {2'h0, ix[i]});
      foreach (ix[i]) wreg(ix[i], 8'h00);
      wreg(6'h35, 8'hFF);
      rchk(6'h35, 8'hF3);
      wreg(6'h35, 8'h00);
      rchk(6'h20, 8'h00);                           // Unmapped reads zero
      $display("t_regs done");
   endtask : t_regs
   task automatic t_plain;
      ext_en <= 32'h000000F0; ext_drv <= 32'h000000A0;
      wreg(6'h01, 8'h0F); wreg(6'h02, 8'h55);
      repeat (6) @(posedge clk);
      `CHK("a_oe", 8'h0F, poe[7:0])
      `CHK("a_out", 4'h5, pout[3:0])
      `CHK("a_pu", 8'h50, ppu[7:0])
      rchk(6'h00, 8'hA5);
      wreg(6'h35, 8'h10);
      repeat (3) @(posedge clk);
      `CHK("pud", 32'h0, ppu)
      wreg(6'h35, 8'h00); wreg(6'h01, 8'h00); wreg(6'h02, 8'h00);
      $display("t_plain done");
   endtask : t_plain
   task automatic t_serial;
      tx0 <= 1'b1; tx1 <= 1'b0;
      wreg(6'h0B, 8'h05); wreg(6'h3E, 8'h0F);
      repeat (3) @(posedge clk);
      `CHK("d_oe", 4'hA, poe[27:24])
      `CHK("d_tx", 2'b01, {pout[27], pout[25]})
      `CHK("d_pu", 4'h5, ppu[27:24])
      wreg(6'h0A, 8'hFF); tx0 <= 1'b0; tx1 <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK("d_oe2", 4'hA, poe[27:24])
      `CHK("d_tx2", 2'b10, {pout[27], pout[25]})
      wreg(6'h35, 8'h10);
      repeat (3) @(posedge clk);
      `CHK("d_pud", 4'h0, ppu[27:24])
      wreg(6'h35, 8'h00); wreg(6'h3E, 8'h00); wreg(6'h0A, 8'h00); wreg(6'h0B, 8'h00);
      $display("t_serial done");
   endtask : t_serial
   task automatic t_cmp;
      wreg(6'h0A, 8'hF0); cmp <= 4'hA; cmp_on <= 4'hF;
      repeat (3) @(posedge clk);
      `CHK("cmp_out", 4'hA, pout[31:28])
      `CHK("cmp_oe", 4'hF, poe[31:28])
      cmp_on <= 4'h0;
      repeat (3) @(posedge clk);
      `CHK("cmp_off", 4'h0, pout[31:28])
      wreg(6'h0A, 8'h00);
      $display("t_cmp done");
   endtask : t_cmp
   task automatic t_ie;
      ext_en <= 32'hFF000000; ext_drv <= 32'h04000000;
      wreg(6'h3F, 8'h04);
      repeat (2) @(posedge clk);
      `CHK("ie_mask_only", 1'b0, dien[2])
      wreg(6'h3E, 8'h10);
      repeat (6) @(posedge clk);
      `CHK("ie_pc", 1'b1, dien[2])
      `CHK("di_pc", 1'b1, die[2])
      wreg(6'h3F, 8'h00); wreg(6'h3E, 8'h60);
      repeat (3) @(posedge clk);
      `CHK("ie_ext", 2'b11, dien[3:2])
      rchk(6'h09, 8'h04);
      $display("t_ie done");
   endtask : t_ie
   // ----------------------------------------
   // Verdict, clock, watchdog, main sequence
   // ----------------------------------------
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : wrap_up
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #200000;                                      // Far beyond the few hundred cycles needed
      error_cnt++;
      wrap_up();
   end
   initial begin
      nrst = 1'b0; rd = 1'b0; wr = 1'b0; addr = 8'h00; wdat = 32'h0; tx0 = 1'b0; tx1 = 1'b0;
      cmp = 4'h0; cmp_on = 4'h0; ext_drv = 32'h0; ext_en = 32'h0; error_cnt = 0; comparisons = 0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_regs(); t_plain(); t_serial(); t_cmp(); t_ie();
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
